/* core/edge_catcher.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// per-line edge detector: rising only, or both edges
module edge_catcher (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // line and mode
  input  wire logic level_in,
  input  wire logic both_edges,
  // one-cycle event
  output logic      edge_pulse
);

  typedef struct packed {
    logic prev;
    logic armed;
  } edge_state_t;

  edge_state_t s_q;
  edge_state_t s_d;

  // compare the line with its last sample
  always_comb begin
    s_d       = s_q;
    s_d.prev  = level_in;
    s_d.armed = 1'b1;
    if (!s_q.armed) begin
      edge_pulse = 1'b0;
    end else if (both_edges) begin
      edge_pulse = level_in ^ s_q.prev;
    end else begin
      edge_pulse = level_in & ~s_q.prev;
    end
  end

  // first sample after reset only arms the detector
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

/* core/irq_funnel_pkg.sv */
package irq_funnel_pkg;

  // ==========================================================
  // register addresses on the peripheral port
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h0F;

  // ==========================================================
  // reset values
  localparam logic [7:0] EVENT_STATUS_RST = 8'h00;
  localparam logic [7:0] EVENT_ENABLE_RST = 8'h00;

  // ==========================================================
  // status / enable bit positions
  localparam int BIT_POWER_FAIL    = 7;
  localparam int BIT_DIR_CHANGE    = 6;
  localparam int BIT_CONVERTER     = 5;
  localparam int BIT_DETECT_EDGE   = 4;
  localparam int BIT_CHG_OVERCURR  = 3;
  localparam int BIT_DIS_OVERCURR  = 2;
  localparam int BIT_CHG_WRAP      = 1;
  localparam int BIT_DIS_WRAP      = 0;
  localparam int EVENT_COUNT       = 8;

  // ==========================================================
  // sleep control states
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_SLEEP = 1'b1
  } sleep_state_t;

endpackage

/* core/peripheral_interrupt_funnel.sv */
// What this block does
// RQ1: each enable bit set passes its status bit to the core interrupt
// RQ2: reading the enable register never changes it
// RQ3: enable bits clear to zero on master clear or power-on reset
// RQ4: status bits latch events even when their enable bit is zero
// RQ5: writing one to a status bit clears that flag
// RQ6: status bits map power fail down to discharge wrap, all reset zero
// RQ7: status register sits at port address 0E, read and write
// RQ8: enable register sits at port address 0F, read, write, resets zero
// RQ9: power-fail flag latches on supply crossing three volts either way
// RQ10: detect flag latches on either edge of the detect pin
// RQ11: any interrupt reaching the core wakes it from sleep
// RQ12: a configuration bit chooses to stop the oscillator during sleep
// RQ13: the oscillator restarts whenever sleep ends, regardless of that bit
// RQ14: reading the status register never changes any flag
// RQ15: core interrupt is level OR of status AND enable
// RQ16: writing zero keeps a flag; an event during clear stays latched
`timescale 1ns/10ps
`default_nettype none

module peripheral_interrupt_funnel (
  // clock and resets
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       master_clear_n,
  // peripheral port
  input  wire logic [7:0] port_addr,
  input  wire logic [7:0] port_wdata,
  input  wire logic       port_wr,
  input  wire logic       port_rd,
  output logic      [7:0] port_rdata,
  // event sources
  input  wire logic       supply_above_3v,
  input  wire logic       gauge_charge_dir,
  input  wire logic       converter_event,
  input  wire logic       detect_pin,
  input  wire logic       charge_overcurrent,
  input  wire logic       discharge_overcurrent,
  input  wire logic       charge_counter_wrap,
  input  wire logic       discharge_counter_wrap,
  // sleep and oscillator control, core interrupt
  input  wire logic       sleep_req,
  input  wire logic       osc_off_in_sleep,
  output logic            core_irq_three,
  output logic            core_asleep,
  output logic            osc_enable
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]                  status;
    logic [7:0]                  enable;
    logic [7:0]                  rdata;
    logic                        irq;
    irq_funnel_pkg::sleep_state_t sleep;
    logic                        osc_en;
  } funnel_state_t;

  funnel_state_t s_q;
  funnel_state_t s_d;

  logic [7:0] raw_lines;
  logic [7:0] both_mask;
  logic [7:0] event_pulse;
  logic [7:0] pending;
  logic       wr_status;
  logic       wr_enable;

  // ==========================================================
  // event source map
  assign raw_lines = {supply_above_3v, gauge_charge_dir, converter_event,
                      detect_pin, charge_overcurrent, discharge_overcurrent,
                      charge_counter_wrap, discharge_counter_wrap}; // [RQ6]
  // supply, direction and detect pin fire on both edges
  assign both_mask = 8'hD0; // [RQ9] [RQ10]

  // one edge detector per source
  genvar gi;
  generate
    for (gi = 0; gi < irq_funnel_pkg::EVENT_COUNT; gi++) begin : g_src
      edge_catcher u_edge (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .level_in   (raw_lines[gi]),
        .both_edges (both_mask[gi]),
        .edge_pulse (event_pulse[gi])
      );
    end
  endgenerate

  // address decode
  assign wr_status = port_wr
    && (port_addr == irq_funnel_pkg::ADDR_EVENT_STATUS); // [RQ7]
  assign wr_enable = port_wr
    && (port_addr == irq_funnel_pkg::ADDR_EVENT_ENABLE); // [RQ8]

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d = s_q;
    // w1c clear, set wins, reads leave flags alone
    if (wr_status) begin
      s_d.status = s_q.status & ~port_wdata; // [RQ5] [RQ14]
    end
    s_d.status = s_d.status | event_pulse; // [RQ4] [RQ16]
    if (wr_enable) begin
      s_d.enable = port_wdata; // [RQ2]
    end
    // master clear wipes the mask before the irq term sees it
    if (!master_clear_n) begin
      s_d.enable = irq_funnel_pkg::EVENT_ENABLE_RST; // [RQ3]
    end
    // read data, unmapped reads as zero
    s_d.rdata = 8'h00;
    if (port_rd) begin
      if (port_addr == irq_funnel_pkg::ADDR_EVENT_STATUS) begin
        s_d.rdata = s_q.status; // [RQ7]
      end else if (port_addr == irq_funnel_pkg::ADDR_EVENT_ENABLE) begin
        s_d.rdata = s_q.enable; // [RQ2] [RQ8]
      end
    end
    pending  = s_d.status & s_d.enable; // [RQ1]
    s_d.irq  = |pending; // [RQ15]
    // sleep entry and wake
    case (s_q.sleep)
      irq_funnel_pkg::ST_RUN: begin
        if (sleep_req && !(|pending)) begin
          s_d.sleep  = irq_funnel_pkg::ST_SLEEP;
          s_d.osc_en = !osc_off_in_sleep; // [RQ12]
        end
      end
      default: begin
        if (|pending) begin
          s_d.sleep  = irq_funnel_pkg::ST_RUN; // [RQ11]
          s_d.osc_en = 1'b1; // [RQ13]
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q.status <= irq_funnel_pkg::EVENT_STATUS_RST;
      s_q.enable <= irq_funnel_pkg::EVENT_ENABLE_RST; // [RQ3]
      s_q.rdata  <= 8'h00;
      s_q.irq    <= 1'b0;
      s_q.sleep  <= irq_funnel_pkg::ST_RUN;
      s_q.osc_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign port_rdata     = s_q.rdata;
  assign core_irq_three = s_q.irq;
  assign core_asleep    = (s_q.sleep == irq_funnel_pkg::ST_SLEEP);
  assign osc_enable     = s_q.osc_en;

  // ==========================================================
  // checks
  sequence s_clear_write;
    wr_status && (port_wdata[0] == 1'b1) && !event_pulse[0];
  endsequence

  property p_mask_gate;
    @(posedge core_clk) disable iff (!nrst)
      1'b1 |=> core_irq_three == |($past(s_d.status) & $past(s_d.enable));
  endproperty
  a_mask_gate: assert property (p_mask_gate) // [RQ1]
    else $error("irq mismatch");

  property p_read_keeps_enable;
    @(posedge core_clk) disable iff (!nrst)
      (port_rd && !port_wr && master_clear_n) |=> $stable(s_q.enable);
  endproperty
  a_read_keeps_enable: assert property (p_read_keeps_enable) // [RQ2]
    else $error("enable changed");

  property p_master_clear_n;
    @(posedge core_clk) disable iff (!nrst)
      !master_clear_n |=> s_q.enable == 8'h00;
  endproperty
  a_master_clear_n: assert property (p_master_clear_n) // [RQ3]
    else $error("enable not cleared");

  property p_latch_masked;
    @(posedge core_clk) disable iff (!nrst)
      (event_pulse[5] && !s_q.enable[5]) |=> s_q.status[5];
  endproperty
  a_latch_masked: assert property (p_latch_masked) // [RQ4]
    else $error("event lost");

  property p_w1c;
    @(posedge core_clk) disable iff (!nrst)
      s_clear_write |=> !s_q.status[0];
  endproperty
  a_w1c: assert property (p_w1c) // [RQ5]
    else $error("flag not cleared");

  property p_read_keeps_status;
    @(posedge core_clk) disable iff (!nrst)
      (port_rd && !port_wr && s_q.status[3]) |=> s_q.status[3];
  endproperty
  a_read_keeps_status: assert property (p_read_keeps_status) // [RQ14]
    else $error("status lost");

  property p_set_wins;
    @(posedge core_clk) disable iff (!nrst)
      (wr_status && event_pulse[2]) |=> s_q.status[2];
  endproperty
  a_set_wins: assert property (p_set_wins) // [RQ16]
    else $error("set lost to clear");

  property p_wake;
    @(posedge core_clk) disable iff (!nrst)
      (core_asleep && |(s_d.status & s_d.enable))
        |=> !core_asleep && osc_enable;
  endproperty
  a_wake: assert property (p_wake) // [RQ11]
    else $error("no wake");

  property p_osc_sleep;
    @(posedge core_clk) disable iff (!nrst)
      ($rose(core_asleep)) |-> osc_enable == !$past(osc_off_in_sleep);
  endproperty
  a_osc_sleep: assert property (p_osc_sleep) // [RQ12]
    else $error("osc setting wrong");

endmodule

`default_nettype wire

/* testbench/event_source_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// peripheral event sources seen by the funnel
module event_source_model (
  // clock
  input  wire logic       core_clk,
  // source levels
  output logic      [7:0] src
);
  initial src = 8'h00;

  // dual-edge lines toggle once, pulse lines rise then fall
  task automatic kick(input logic [7:0] m);
    @(negedge core_clk);
    src = src ^ m;
    @(negedge core_clk);
    src = src & ~(m & 8'h2F);
  endtask
endmodule
`default_nettype wire

/* testbench/peripheral_interrupt_funnel_bench.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// self-checking bench for the interrupt funnel
module peripheral_interrupt_funnel_bench;
  logic       core_clk, nrst, master_clear_n, port_wr, port_rd;
  logic [7:0] port_addr, port_wdata, port_rdata;
  logic       sleep_req, osc_off_in_sleep;
  logic       core_irq_three, core_asleep, osc_enable;
  wire  [7:0] src;
  int         err_count, check_count;

  event_source_model i_src (.core_clk(core_clk), .src(src));

  peripheral_interrupt_funnel i_dut (
    .core_clk(core_clk), .nrst(nrst), .master_clear_n(master_clear_n),
    .port_addr(port_addr), .port_wdata(port_wdata), .port_wr(port_wr),
    .port_rd(port_rd), .port_rdata(port_rdata),
    .supply_above_3v(src[7]), .gauge_charge_dir(src[6]),
    .converter_event(src[5]), .detect_pin(src[4]),
    .charge_overcurrent(src[3]), .discharge_overcurrent(src[2]),
    .charge_counter_wrap(src[1]), .discharge_counter_wrap(src[0]),
    .sleep_req(sleep_req), .osc_off_in_sleep(osc_off_in_sleep),
    .core_irq_three(core_irq_three), .core_asleep(core_asleep),
    .osc_enable(osc_enable));

  // ==========================================================
  // shared helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk);
    port_addr = a;
    port_wdata = d;
    port_wr = 1'b1;
    @(negedge core_clk);
    port_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(negedge core_clk);
    port_addr = a;
    port_rd = 1'b1;
    @(negedge core_clk);
    port_rd = 1'b0;
    check(port_rdata, exp, "read data");
  endtask

  // bounded wait for the core interrupt level
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 8 && core_irq_three !== exp; i++)
      @(negedge core_clk);
    check({7'h00, core_irq_three}, {7'h00, exp}, "core irq");
    if (core_irq_three !== exp) give_verdict();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h00);
    rd(8'h0D, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_latch();
    i_src.kick(8'hFF);
    idle(3);
    rd(8'h0E, 8'hFF);
    rd(8'h0E, 8'hFF);
    wait_irq(1'b0);
    wr(8'h0E, 8'h90);
    rd(8'h0E, 8'h6F);
    i_src.kick(8'h90);
    idle(3);
    rd(8'h0E, 8'hFF);
    $display("test latch done");
  endtask

  task automatic t_mask();
    for (int i = 0; i < 8; i++) begin
      wr(8'h0F, 8'h01 << i);
      wait_irq(1'b1);
      rd(8'h0F, 8'h01 << i);
      rd(8'h0F, 8'h01 << i);
    end
    wr(8'h0F, 8'h00);
    wait_irq(1'b0);
    $display("test mask done");
  endtask

  task automatic t_clear();
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'h0F);
    rd(8'h0E, 8'hF0);
    wait_irq(1'b1);
    wr(8'h0E, 8'hF0);
    rd(8'h0E, 8'h00);
    // event and clearing write land on the same edge
    fork
      i_src.kick(8'h04);
      wr(8'h0E, 8'h04);
    join
    rd(8'h0E, 8'h04);
    wr(8'h0E, 8'h04);
    rd(8'h0E, 8'h00);
    wait_irq(1'b0);
    $display("test clear done");
  endtask

  task automatic t_master_clear_n();
    wr(8'h0F, 8'hA5);
    @(negedge core_clk);
    master_clear_n = 1'b0;
    idle(1);
    master_clear_n = 1'b1;
    rd(8'h0F, 8'h00);
    // mid-run reset wipes both registers
    i_src.kick(8'h01);
    wr(8'h0F, 8'h5A);
    rd(8'h0E, 8'h01);
    @(negedge core_clk);
    nrst = 1'b0;
    idle(2);
    nrst = 1'b1;
    idle(1);
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h00);
    $display("test master clear done");
  endtask

  task automatic t_sleep();
    sleep_req = 1'b1;
    idle(3);
    check({6'h00, core_asleep, osc_enable}, 8'h03, "sleep osc on");
    // only an interrupt ends sleep
    sleep_req = 1'b0;
    wr(8'h0F, 8'h08);
    i_src.kick(8'h08);
    idle(3);
    check({6'h00, core_asleep, osc_enable}, 8'h01, "wake osc on");
    wr(8'h0E, 8'h08);
    osc_off_in_sleep = 1'b1;
    sleep_req = 1'b1;
    idle(3);
    check({6'h00, core_asleep, osc_enable}, 8'h02, "sleep osc off");
    i_src.kick(8'h08);
    idle(3);
    check({7'h00, core_asleep}, 8'h00, "wake");
    check({7'h00, osc_enable}, 8'h01, "osc restart");
    sleep_req = 1'b0;
    osc_off_in_sleep = 1'b0;
    $display("test sleep done");
  endtask

  // ==========================================================
  // clock and main sequence
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    nrst = 1'b0;
    master_clear_n = 1'b1;
    port_addr = 8'h00;
    port_wdata = 8'h00;
    port_wr = 1'b0;
    port_rd = 1'b0;
    sleep_req = 1'b0;
    osc_off_in_sleep = 1'b0;
    idle(5);
    nrst = 1'b1;
    idle(1);
    t_reset();
    t_latch();
    t_mask();
    t_clear();
    t_master_clear_n();
    t_sleep();
    give_verdict();
  end
endmodule
`default_nettype wire
